/* rtl/ascm_top.v */
// analog scale compare monitor top with apb registers
`timescale 1ns/1ps
`include "ascm_consts.vh"
// Notes on behaviour
// [RULE1] operands range zero to 1000
// [RULE2] both comparator operands scaled, offset added
// [RULE3] difference is primary minus second
// [RULE4] set above set level, clear at clear
// [RULE5] inverted thresholds: high inside the band
// [RULE6] decimals setting ignored by comparisons
// [RULE7] on-delay filtering left to outside logic
// [RULE8] off-delay filtering left to outside logic
// [RULE9] strobe rising edge captures primary input
// [RULE10] capture and live both scaled
// [RULE11] set when strobe high and outside band; code still clears the switch in the cycle of the strobe rising edge
// [RULE12] clear inside band or strobe low
// [RULE13] window width signed, within twenty thousand
// [RULE14] offset signed within ten thousand, added
// [RULE15] amplifier outputs scaled primary input
// [RULE16] output is signed sixteen bit
// [RULE17] output feeds only blocks or flags
// [RULE18] hold output between hysteresis thresholds
// [RULE19] amplifier result saturates, never wraps
// [RULE20] outputs registered once per cycle
module ascm_top (
   input wire I_CLK_SYS,
   input wire I_RESETN,
   input wire I_CYCLE_EN,
   input wire [`ASCM_IN_W-1:0] I_PRIMARY_ANALOG_IN,
   input wire [`ASCM_IN_W-1:0] I_SECOND_ANALOG_IN,
   input wire I_CAPTURE_STROBE,
   input wire I_PSEL,
   input wire I_PENABLE,
   input wire I_PWRITE,
   input wire [11:0] I_PADDR,
   input wire [31:0] I_PWDATA,
   output wire [31:0] O_PRDATA,
   output wire O_PREADY,
   output wire O_PSLVERR,
   output wire O_SWITCH_OUT,
   output wire [15:0] O_SCALED_ANALOG_OUT
);
////////////////////////////////////////////////////////////////////////////
   reg [`ASCM_MODE_W-1:0] mode_q;
   reg [`ASCM_GAIN_W-1:0] gain_q;
   reg [`ASCM_PAR_W-1:0] ofs_q;
   reg [`ASCM_PAR_W-1:0] set_q;
   reg [`ASCM_PAR_W-1:0] clr_q;
   reg [`ASCM_PAR_W-1:0] win_q;
   reg [1:0] frac_q;
   reg [`ASCM_IN_W-1:0] cap_q;
   reg switch_q;
   reg [15:0] out_q;
   reg strobe_prev_q;
   reg [31:0] prdata_q;
   wire wr;
   wire rd;
   wire hit;
   wire [15:0] w16;
   wire [15:0] ofs_abs;
   wire [15:0] win_abs;
   wire [15:0] gain_w;
   assign wr = I_PSEL & I_PENABLE & I_PWRITE;
   assign rd = I_PSEL & ~I_PENABLE & ~I_PWRITE;
   assign hit = (I_PADDR == `ASCM_ADDR_MODE) | (I_PADDR == `ASCM_ADDR_GAIN) |
      (I_PADDR == `ASCM_ADDR_OFS) | (I_PADDR == `ASCM_ADDR_SET) |
      (I_PADDR == `ASCM_ADDR_CLR) | (I_PADDR == `ASCM_ADDR_WIN) |
      (I_PADDR == `ASCM_ADDR_FRAC) | (I_PADDR == `ASCM_ADDR_STAT) |
      (I_PADDR == `ASCM_ADDR_CAP) | (I_PADDR == `ASCM_ADDR_OUT);
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = I_PSEL & I_PENABLE & ~hit;
   assign O_PRDATA = prdata_q;
   assign w16 = I_PWDATA[15:0];
   assign ofs_abs = w16[15] ? (16'h0000 - w16) : w16;
   assign win_abs = w16;
   assign gain_w = w16;
////////////////////////////////////////////////////////////////////////////
   // register writes, out of range values refused
   always @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         mode_q <= `ASCM_MODE_CMP;
         gain_q <= `ASCM_RST_GAIN;
         ofs_q <= 16'h0000;
         set_q <= 16'h0000;
         clr_q <= 16'h0000;
         win_q <= 16'h0000;
         frac_q <= 2'h0;
      end else if (wr) begin
         if (I_PADDR == `ASCM_ADDR_MODE && w16[1:0] != 2'h3) begin
            mode_q <= w16[1:0];
         end
         if (I_PADDR == `ASCM_ADDR_GAIN &&
             gain_w <= {5'h00, `ASCM_GAIN_MAX}) begin
            gain_q <= gain_w[`ASCM_GAIN_W-1:0];
         end
         if (I_PADDR == `ASCM_ADDR_OFS && ofs_abs <= `ASCM_OFS_MAX) begin
            ofs_q <= w16; // [RULE14]
         end
         if (I_PADDR == `ASCM_ADDR_SET && ofs_abs <= `ASCM_WIN_MAX) begin
            set_q <= w16;
         end
         if (I_PADDR == `ASCM_ADDR_CLR && ofs_abs <= `ASCM_WIN_MAX) begin
            clr_q <= w16;
         end
         if (I_PADDR == `ASCM_ADDR_WIN && ofs_abs <= `ASCM_WIN_MAX) begin
            win_q <= w16; // [RULE13]
         end
         if (I_PADDR == `ASCM_ADDR_FRAC) begin
            frac_q <= w16[1:0]; // [RULE6]
         end
      end
   end
////////////////////////////////////////////////////////////////////////////
   // read data captured in setup phase
   always @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         prdata_q <= 32'h00000000;
      end else if (rd) begin
         case (I_PADDR)
            `ASCM_ADDR_MODE: prdata_q <= {30'h00000000, mode_q};
            `ASCM_ADDR_GAIN: prdata_q <= {21'h000000, gain_q};
            `ASCM_ADDR_OFS: prdata_q <= {16'h0000, ofs_q};
            `ASCM_ADDR_SET: prdata_q <= {16'h0000, set_q};
            `ASCM_ADDR_CLR: prdata_q <= {16'h0000, clr_q};
            `ASCM_ADDR_WIN: prdata_q <= {16'h0000, win_q};
            `ASCM_ADDR_FRAC: prdata_q <= {30'h00000000, frac_q};
            `ASCM_ADDR_STAT: prdata_q <= {31'h00000000, switch_q};
            `ASCM_ADDR_CAP: prdata_q <= {22'h000000, cap_q};
            `ASCM_ADDR_OUT: prdata_q <= {16'h0000, out_q};
            default: prdata_q <= 32'h00000000;
         endcase
      end
   end
////////////////////////////////////////////////////////////////////////////
   wire [`ASCM_WIDE_W-1:0] act_x;
   wire [`ASCM_WIDE_W-1:0] act_y;
   wire [`ASCM_WIDE_W-1:0] act_c;
   wire [`ASCM_IN_W-1:0] y_sel;
   assign y_sel = (mode_q == `ASCM_MODE_MON) ? cap_q : I_SECOND_ANALOG_IN;
   ascm_scale u_scale_x (
      .i_val(I_PRIMARY_ANALOG_IN),
      .i_gain(gain_q),
      .i_ofs(ofs_q),
      .o_res(act_x)
   ); // [RULE2]
   ascm_scale u_scale_y (
      .i_val(y_sel),
      .i_gain(gain_q),
      .i_ofs(ofs_q),
      .o_res(act_y)
   ); // [RULE10]
   assign act_c = act_y;
   wire signed [`ASCM_WIDE_W-1:0] diff;
   wire signed [`ASCM_WIDE_W-1:0] set_s;
   wire signed [`ASCM_WIDE_W-1:0] clr_s;
   wire signed [`ASCM_WIDE_W-1:0] win_s;
   wire signed [`ASCM_WIDE_W-1:0] lo_s;
   wire signed [`ASCM_WIDE_W-1:0] hi_s;
   wire signed [`ASCM_WIDE_W-1:0] ax_s;
   assign diff = act_x - act_y; // [RULE3]
   assign set_s = {{16{set_q[15]}}, set_q}; // [RULE6]
   assign clr_s = {{16{clr_q[15]}}, clr_q};
   assign win_s = {{16{win_q[15]}}, win_q};
   assign ax_s = act_x;
   // band limits ordered for negative widths too
   assign lo_s = win_q[15] ? (act_c + win_s) : (act_c - win_s);
   assign hi_s = win_q[15] ? (act_c - win_s) : (act_c + win_s);
   wire strobe_rise;
   assign strobe_rise = I_CAPTURE_STROBE & ~strobe_prev_q;
////////////////////////////////////////////////////////////////////////////
   reg switch_d;
   reg [15:0] out_d;
   always @* begin
      switch_d = switch_q;
      out_d = out_q;
      case (mode_q)
         `ASCM_MODE_CMP: begin
            if (set_s >= clr_s) begin
               if (diff > set_s) begin
                  switch_d = 1'b1; // [RULE4]
               end else if (diff <= clr_s) begin
                  switch_d = 1'b0; // [RULE4]
               end else begin
                  switch_d = switch_q; // [RULE18]
               end
            end else begin
               switch_d = (diff >= set_s) && (diff < clr_s); // [RULE5]
            end
         end
         `ASCM_MODE_MON: begin
            if (!I_CAPTURE_STROBE || strobe_rise) begin
               switch_d = 1'b0; // [RULE12]
            end else begin
               switch_d = (ax_s < lo_s) || (ax_s > hi_s); // [RULE11]
            end
         end
         `ASCM_MODE_AMP: begin
            switch_d = 1'b0;
            if ($signed(act_x) > $signed(`ASCM_OUT_MAX)) begin
               out_d = 16'h7fff; // [RULE19]
            end else if ($signed(act_x) < $signed(`ASCM_OUT_MIN)) begin
               out_d = 16'h8000; // [RULE19]
            end else begin
               out_d = act_x[15:0]; // [RULE15] [RULE16]
            end
         end
         default: begin
            switch_d = 1'b0;
         end
      endcase
   end
////////////////////////////////////////////////////////////////////////////
   // evaluation on each program cycle enable
   always @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         switch_q <= 1'b0;
         out_q <= 16'h0000;
         cap_q <= {`ASCM_IN_W{1'b0}};
         strobe_prev_q <= 1'b0;
      end else if (I_CYCLE_EN) begin
         switch_q <= switch_d; // [RULE20]
         out_q <= out_d; // [RULE20]
         strobe_prev_q <= I_CAPTURE_STROBE;
         if (mode_q == `ASCM_MODE_MON && strobe_rise) begin
            cap_q <= I_PRIMARY_ANALOG_IN; // [RULE9]
         end
      end
   end
   assign O_SWITCH_OUT = switch_q;
   assign O_SCALED_ANALOG_OUT = out_q;
endmodule

/* include/ascm_consts.vh */
// constants for the analog scale compare monitor
`ifndef ASCM_CONSTS_VH
`define ASCM_CONSTS_VH
`define ASCM_IN_W 10
`define ASCM_IN_MAX 10'h3e8
`define ASCM_GAIN_W 11
`define ASCM_GAIN_MAX 11'h3e8
`define ASCM_GAIN_FRAC 32'h00000064
`define ASCM_PAR_W 16
`define ASCM_OFS_MAX 16'h2710
`define ASCM_WIN_MAX 16'h4e20
`define ASCM_WIDE_W 32
`define ASCM_OUT_MAX 32'h00007fff
`define ASCM_OUT_MIN 32'hffff8000
`define ASCM_MODE_W 2
`define ASCM_MODE_CMP 2'h0
`define ASCM_MODE_MON 2'h1
`define ASCM_MODE_AMP 2'h2
`define ASCM_ADDR_MODE 12'h000
`define ASCM_ADDR_GAIN 12'h004
`define ASCM_ADDR_OFS 12'h008
`define ASCM_ADDR_SET 12'h00c
`define ASCM_ADDR_CLR 12'h010
`define ASCM_ADDR_WIN 12'h014
`define ASCM_ADDR_FRAC 12'h018
`define ASCM_ADDR_STAT 12'h01c
`define ASCM_ADDR_CAP 12'h020
`define ASCM_ADDR_OUT 12'h024
`define ASCM_RST_GAIN 11'h064
`endif

/* rtl/ascm_scale.v */
// operand scaler: input times gain plus offset
`timescale 1ns/1ps
`include "ascm_consts.vh"
module ascm_scale (
   input wire [`ASCM_IN_W-1:0] i_val,
   input wire [`ASCM_GAIN_W-1:0] i_gain,
   input wire [`ASCM_PAR_W-1:0] i_ofs,
   output wire [`ASCM_WIDE_W-1:0] o_res
);
   wire [`ASCM_WIDE_W-1:0] prod;
   wire [`ASCM_WIDE_W-1:0] ofs_ext;
   wire [`ASCM_IN_W-1:0] val_sat;
   // input clipped to the internal full scale
   assign val_sat = (i_val > `ASCM_IN_MAX) ? `ASCM_IN_MAX : i_val; // [RULE1]
   // gain in hundredths
   assign prod = ({22'h000000, val_sat} * {21'h000000, i_gain})
      / `ASCM_GAIN_FRAC;
   assign ofs_ext = {{16{i_ofs[`ASCM_PAR_W-1]}}, i_ofs};
   assign o_res = prod + ofs_ext; // [RULE14]
endmodule

/* tb/ascm_properties.sv */
// checker for the analog scale compare monitor ports
`timescale 1ns/1ps
`include "ascm_consts.vh"
module ascm_props (
   input wire I_CLK_SYS,
   input wire I_RESETN,
   input wire I_CYCLE_EN,
   input wire [`ASCM_IN_W-1:0] I_PRIMARY_ANALOG_IN,
   input wire [`ASCM_IN_W-1:0] I_SECOND_ANALOG_IN,
   input wire I_CAPTURE_STROBE,
   input wire I_PSEL,
   input wire I_PENABLE,
   input wire I_PWRITE,
   input wire [11:0] I_PADDR,
   input wire [31:0] I_PWDATA,
   input wire [31:0] O_PRDATA,
   input wire O_PREADY,
   input wire O_PSLVERR,
   input wire O_SWITCH_OUT,
   input wire [15:0] O_SCALED_ANALOG_OUT
);
   logic [1:0] mode_q;
   always @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN)
         mode_q <= 2'h0;
      else if (I_PSEL && I_PENABLE && I_PWRITE &&
               I_PADDR == `ASCM_ADDR_MODE && I_PWDATA[1:0] != 2'h3)
         mode_q <= I_PWDATA[1:0];
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESETN);
   sequence s_bad_acc; I_PSEL && I_PENABLE && I_PADDR > `ASCM_ADDR_OUT;
   endsequence
   sequence s_idle; !I_CYCLE_EN; endsequence
   sequence s_mon_low; mode_q == `ASCM_MODE_MON && I_CYCLE_EN &&
      !I_CAPTURE_STROBE; endsequence
   a_ready_high: assert property (O_PREADY)
      else $error("pready low");
   a_slverr_bad: assert property (s_bad_acc |-> O_PSLVERR)
      else $error("no slverr on unmapped");
   a_slverr_good: assert property (I_PSEL && I_PENABLE &&
      I_PADDR <= `ASCM_ADDR_OUT && I_PADDR[1:0] == 2'h0 |-> !O_PSLVERR)
      else $error("slverr on mapped");
   a_rdata_hold: assert property (!(I_PSEL && !I_PENABLE &&
      !I_PWRITE) |=> $stable(O_PRDATA)) else $error("prdata moved");
   a_sw_idle: assert property (s_idle |=> $stable(O_SWITCH_OUT))
      else $error("switch moved off cycle");
   a_out_idle: assert property (s_idle |=>
      $stable(O_SCALED_ANALOG_OUT)) else $error("out moved off cycle");
   a_amp_sw_low: assert property (mode_q == `ASCM_MODE_AMP &&
      I_CYCLE_EN |=> !O_SWITCH_OUT) else $error("switch high in amp");
   a_out_mode_hold: assert property (mode_q != `ASCM_MODE_AMP |=>
      $stable(O_SCALED_ANALOG_OUT)) else $error("out moved off amp");
   a_mon_strobe_low: assert property (s_mon_low |=>
      !O_SWITCH_OUT) else $error("switch high with strobe low");
endmodule
bind ascm_top ascm_props u_props (.I_CLK_SYS(I_CLK_SYS),
   .I_RESETN(I_RESETN), .I_CYCLE_EN(I_CYCLE_EN),
   .I_PRIMARY_ANALOG_IN(I_PRIMARY_ANALOG_IN),
   .I_SECOND_ANALOG_IN(I_SECOND_ANALOG_IN),
   .I_CAPTURE_STROBE(I_CAPTURE_STROBE), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
   .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
   .O_PSLVERR(O_PSLVERR), .O_SWITCH_OUT(O_SWITCH_OUT),
   .O_SCALED_ANALOG_OUT(O_SCALED_ANALOG_OUT));

/* tb/ascm_src.sv */
// analog channel model feeding the operands and taking the results
`timescale 1ns/1ps
module ascm_src #(
   parameter DLY = 4
) (
   input wire i_clk,
   input wire i_ld,
   input wire [9:0] i_x,
   input wire [9:0] i_y,
   input wire i_sw,
   input wire [15:0] i_aq,
   output logic [9:0] o_x,
   output logic [9:0] o_y,
   output logic o_sw_flt,
   output logic [15:0] o_flag
);
   logic [2:0] cnt;
   initial begin
      o_x = 10'h000;
      o_y = 10'h000;
      o_sw_flt = 1'b0;
      o_flag = 16'h0000;
      cnt = 3'h0;
   end
   always @(posedge i_clk) begin
      if (i_ld) begin
         o_x <= i_x > 10'h3e8 ? 10'h3e8 : i_x;
         o_y <= i_y > 10'h3e8 ? 10'h3e8 : i_y;
      end
      // analog flag takes the amplifier output
      o_flag <= i_aq;
      // on-delay and off-delay stage behind the switch
      if (i_sw == o_sw_flt) begin
         cnt <= 3'h0;
      end else if (cnt == DLY - 1) begin
         o_sw_flt <= i_sw;
         cnt <= 3'h0;
      end else begin
         cnt <= cnt + 3'h1;
      end
   end
endmodule

/* tb/ascm_top_tb.sv */
// testbench for the analog scale compare monitor
`timescale 1ns/1ps
`include "ascm_consts.vh"
module ascm_top_tb;
   logic clk = 0, rstn = 0, cyc = 0, stb = 0, ld = 0;
   logic psel = 0, pen = 0, pwr = 0, pready, pslverr, sw, e, q, swf;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [9:0] rx = 10'h000, ry = 10'h000, ax, ay;
   logic [15:0] aout, flag;
   int seed = 32'h929d, err_count = 0, cmp_count = 0, g = 100, o = 0, x, y;
   initial forever #12.5 clk = ~clk;
   ascm_src u_src (.i_clk(clk), .i_ld(ld), .i_x(rx), .i_y(ry), .i_sw(sw),
      .i_aq(aout), .o_x(ax), .o_y(ay), .o_sw_flt(swf), .o_flag(flag));
   ascm_top u_dut (.I_CLK_SYS(clk), .I_RESETN(rstn), .I_CYCLE_EN(cyc),
      .I_PRIMARY_ANALOG_IN(ax), .I_SECOND_ANALOG_IN(ay),
      .I_CAPTURE_STROBE(stb), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .O_SWITCH_OUT(sw),
      .O_SCALED_ANALOG_OUT(aout));
   ////////////////////////////////////////////////////////////////////
   task end_of_test;
      $display("errors %0d checks %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input string n, input [31:0] ex, input [31:0] got);
      cmp_count++;
      if (ex !== got) begin
         $display("unexpected %s expected %h seen %h", n, ex, got);
         err_count++;
      end
   endtask
   task apb(input logic wr, input [11:0] a, input int d);
      @(posedge clk);
      psel <= 1;
      pwr <= wr;
      paddr <= a;
      pwdata <= {16'h0, d[15:0]};
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 0;
      pen <= 0;
   endtask
   task step(input int vx, input int vy, input logic s);
      @(posedge clk);
      ld <= 1;
      rx <= vx[9:0];
      ry <= vy[9:0];
      @(posedge clk);
      ld <= 0;
      cyc <= 1;
      stb <= s;
      @(posedge clk);
      cyc <= 0;
      @(negedge clk);
   endtask
   function int sc(int v);
      return v * g / 100 + o;
   endfunction
   function logic cmp_nx(int d, int s, int c, logic h);
      if (s >= c)
         return d > s ? 1'b1 : (d <= c ? 1'b0 : h);
      return d >= s && d < c;
   endfunction
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1;
      apb(0, `ASCM_ADDR_GAIN, 0);
      chk("gain", 100, r);
      apb(1, `ASCM_ADDR_GAIN, 1001);
      apb(0, `ASCM_ADDR_GAIN, 0);
      chk("gain", 100, r);
      apb(0, 12'h030, 0);
      chk("slverr", 1, e);
      apb(1, `ASCM_ADDR_MODE, 3);
      apb(0, `ASCM_ADDR_MODE, 0);
      chk("mode", 0, r);
      g = 50 + {$random(seed)} % 251;
      o = $random(seed) % 10001;
      apb(1, `ASCM_ADDR_GAIN, g);
      apb(1, `ASCM_ADDR_OFS, o);
      apb(1, `ASCM_ADDR_OFS, 10001);
      apb(0, `ASCM_ADDR_OFS, 0);
      chk("offset", o & 32'hffff, r);
      apb(1, `ASCM_ADDR_FRAC, 3);
      q = 0;
      for (int p = 0; p < 2; p++) begin
         apb(1, `ASCM_ADDR_SET, p ? -100 : 50);
         apb(1, `ASCM_ADDR_CLR, p ? 100 : -50);
         for (int i = 0; i < 30; i++) begin
            x = {$random(seed)} % 1001;
            y = x + $random(seed) % 40;
            y = y < 0 ? 0 : (y > 1000 ? 1000 : y);
            step(x, y, 0);
            q = cmp_nx(sc(x) - sc(y), p ? -100 : 50, p ? 100 : -50,
               q);
            chk("cmp switch", q, sw);
         end
      end
      apb(1, `ASCM_ADDR_MODE, 1);
      apb(1, `ASCM_ADDR_WIN, -20);
      apb(1, `ASCM_ADDR_WIN, 20001);
      step(500, 0, 0);
      step(500, 0, 1);
      chk("mon capture", 0, sw);
      apb(0, `ASCM_ADDR_CAP, 0);
      chk("captured", 500, r);
      for (int i = 0; i < 20; i++) begin
         x = 460 + {$random(seed)} % 81;
         step(x, 0, 1);
         q = sc(x) < sc(500) - 20 || sc(x) > sc(500) + 20;
         chk("mon", q, sw);
      end
      step(0, 0, 1);
      chk("mon outside", 1, sw);
      apb(0, `ASCM_ADDR_STAT, 0);
      chk("status", 1, r);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("on delay", 1, swf);
      step(0, 0, 0);
      chk("mon low", 0, sw);
      chk("off delay", 1, swf);
      g = 1000;
      o = -10000;
      apb(1, `ASCM_ADDR_GAIN, g);
      apb(1, `ASCM_ADDR_OFS, o);
      apb(1, `ASCM_ADDR_MODE, 2);
      for (int i = 0; i < 10; i++) begin
         x = i ? {$random(seed)} % 1001 : 0;
         step(x, 0, 0);
         chk("amp", sc(x) & 32'hffff, {16'h0, aout});
         chk("amp switch", 0, sw);
         @(negedge clk);
         chk("analog flag", sc(x) & 32'hffff, {16'h0, flag});
      end
      apb(0, `ASCM_ADDR_OUT, 0);
      chk("out reg", sc(x) & 32'hffff, r);
      chk("filtered low", 0, swf);
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_of_test();
   end
endmodule
